/* hw/bst_regs.svh */
// Fixed constants of the boundary-scan test access port
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// Instruction register width and capture pattern
`define BST_IR_W          3
`define BST_IR_CAPT       2'h1
`define BST_IR_CAPT_HI    1'h0

// Identification register width and hardwired code (any value with bit 0 set)
`define BST_ID_W          32
`define BST_IDCODE        32'h0a5a_5001

// Boundary chain length and the cell that gates the read-data bus
`define BST_BSR_LEN       109
`define BST_OE_CELL       47

// Rising edges of TCK with mode-select high that force the reset state
`define BST_RST_TMS_CNT   3'h5

// Default opcodes of the implemented instructions
`define BST_OP_EXTEST     3'h0
`define BST_OP_IDCODE     3'h1
`define BST_OP_SAMPZ      3'h2
`define BST_OP_SAMPLE     3'h4
`define BST_OP_BYPASS     3'h7

`endif

/* hw/bst_pkg.sv */
// Types shared by the boundary-scan test access port
package bst_pkg;

  // Controller states of the standard test access port
  typedef enum logic [3:0] {
    ST_TLR,
    ST_RTI,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SH_DR,
    ST_EX1_DR,
    ST_PA_DR,
    ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SH_IR,
    ST_EX1_IR,
    ST_PA_IR,
    ST_EX2_IR,
    ST_UPD_IR
  } bst_tap_st_t;

  // Serial output stage, updated on the falling edge of TCK
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_fall_t;

  // Memory-side view of the test mode
  typedef struct packed {
    logic ovr;
    logic flt;
  } bst_mode_t;

endpackage

/* hw/bst_top.sv */
// Boundary-scan test access port with crossing into the memory clock domain
`include "bst_regs.svh"

module bst_top #(
  parameter int unsigned BSR_LEN   = `BST_BSR_LEN,
  parameter logic [2:0]  OP_EXTEST = `BST_OP_EXTEST,
  parameter logic [2:0]  OP_IDCODE = `BST_OP_IDCODE,
  parameter logic [2:0]  OP_SAMPZ  = `BST_OP_SAMPZ,
  parameter logic [2:0]  OP_SAMPLE = `BST_OP_SAMPLE,
  parameter logic [2:0]  OP_BYPASS = `BST_OP_BYPASS,
  parameter logic [31:0] ID_CODE   = `BST_IDCODE
) (
  input  wire logic               I_SYS_CLK,    // Memory clock, 40 MHz
  input  wire logic               I_RST_N,      // Power-up reset, async, active low
  input  wire logic               I_TCK,        // Test clock
  input  wire logic               I_TMS,        // Mode select level
  input  wire logic               I_TMS_DRV,    // High while mode select is driven
  input  wire logic               I_TDI,        // Serial data in level
  input  wire logic               I_TDI_DRV,    // High while data in is driven
  input  wire logic [BSR_LEN-1:0] I_RING,       // Present pin ring values
  output logic                    O_TDO,        // Serial data out
  output logic                    O_TDO_OE,     // Serial data out enable
  output logic                    O_RING_OVR,   // Boundary values own the pins
  output logic [BSR_LEN-1:0]      O_RING_VAL,   // Boundary values for the pins
  output logic                    O_QBUS_FLOAT  // Read-data bus must float
);

  localparam int unsigned IR_W    = `BST_IR_W;
  localparam int unsigned ID_W    = `BST_ID_W;
  localparam int unsigned OE_CELL = `BST_OE_CELL;
  localparam logic [BSR_LEN-1:0] UPD_RST = BSR_LEN'(1) << OE_CELL;

  // Reserved opcodes fall through to bypass, so only distinct opcodes are served
  if (BSR_LEN <= OE_CELL || ID_CODE[0] != 1'b1 || IR_W != 3 || ID_W != 32 ||
      OP_EXTEST == OP_IDCODE || OP_EXTEST == OP_SAMPZ || OP_EXTEST == OP_SAMPLE ||
      OP_EXTEST == OP_BYPASS || OP_IDCODE == OP_SAMPZ || OP_IDCODE == OP_SAMPLE ||
      OP_IDCODE == OP_BYPASS || OP_SAMPZ == OP_SAMPLE || OP_SAMPZ == OP_BYPASS ||
      OP_SAMPLE == OP_BYPASS) begin : g_chk
    $error("bst_top: unsupported parameter set");
  end

  // State on the rising edge of TCK
  typedef struct packed {
    bst_pkg::bst_tap_st_t st;
    logic [IR_W-1:0]      ir;
    logic [IR_W-1:0]      ir_sh;
    logic                 byp;
    logic [ID_W-1:0]      id_sh;
    logic [BSR_LEN-1:0]   bs_sh;
    logic [BSR_LEN-1:0]   bs_upd;
    logic [BSR_LEN-1:0]   ring_s1;
    logic [BSR_LEN-1:0]   ring_s2;
    logic                 upd_tgl;
  } bst_rise_t;

  // State in the memory clock domain
  typedef struct packed {
    logic               tgl_s1;
    logic               tgl_s2;
    logic               tgl_s3;
    bst_pkg::bst_mode_t mode;
    logic [BSR_LEN-1:0] val;
  } bst_sys_t;

  bst_rise_t         rise_ff;
  bst_rise_t         nxt_rise;
  bst_pkg::bst_fall_t fall_ff;
  bst_pkg::bst_fall_t nxt_fall;
  bst_sys_t          sys_ff;
  bst_sys_t          nxt_sys;

  logic tms_eff;
  logic tdi_eff;
  logic sel_bs;
  logic sel_id;
  logic sel_byp;
  logic in_shift;

  // Internal pull-ups: a floating mode select parks the controller in reset
  assign tms_eff = I_TMS | ~I_TMS_DRV;
  assign tdi_eff = I_TDI | ~I_TDI_DRV;

  // One data register at a time; anything not decoded is bypass
  assign sel_bs  = (rise_ff.ir == OP_EXTEST) || (rise_ff.ir == OP_SAMPLE) ||
                   (rise_ff.ir == OP_SAMPZ);
  assign sel_id  = (rise_ff.ir == OP_IDCODE);
  assign sel_byp = ~sel_bs & ~sel_id;
  assign in_shift = (rise_ff.st == bst_pkg::ST_SH_DR) || (rise_ff.st == bst_pkg::ST_SH_IR);

  always_comb begin
    nxt_rise = rise_ff;
    // Controller walk on mode select
    unique case (rise_ff.st)
      bst_pkg::ST_TLR:    nxt_rise.st = tms_eff ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI:    nxt_rise.st = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: nxt_rise.st = tms_eff ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: nxt_rise.st = tms_eff ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR:  nxt_rise.st = tms_eff ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: nxt_rise.st = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_PA_DR:  nxt_rise.st = tms_eff ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_EX2_DR: nxt_rise.st = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: nxt_rise.st = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: nxt_rise.st = tms_eff ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: nxt_rise.st = tms_eff ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR:  nxt_rise.st = tms_eff ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: nxt_rise.st = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_PA_IR:  nxt_rise.st = tms_eff ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_EX2_IR: nxt_rise.st = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: nxt_rise.st = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
    endcase

    // Pin ring comes from the memory domain; capture reads only the second stage
    nxt_rise.ring_s1 = I_RING;
    nxt_rise.ring_s2 = rise_ff.ring_s1;

    if (rise_ff.st == bst_pkg::ST_TLR) begin
      // Only test state is touched here, memory traffic carries on
      nxt_rise.ir              = OP_IDCODE;
      nxt_rise.bs_upd[OE_CELL] = 1'b1;
    end else if (rise_ff.st == bst_pkg::ST_CAP_IR) begin
      nxt_rise.ir_sh = {`BST_IR_CAPT_HI, `BST_IR_CAPT};
    end else if (rise_ff.st == bst_pkg::ST_SH_IR) begin
      nxt_rise.ir_sh = {tdi_eff, rise_ff.ir_sh[IR_W-1:1]};
    end else if (rise_ff.st == bst_pkg::ST_UPD_IR) begin
      nxt_rise.ir = rise_ff.ir_sh;
    end else if (rise_ff.st == bst_pkg::ST_CAP_DR) begin
      if (sel_bs) begin
        nxt_rise.bs_sh = rise_ff.ring_s2;
      end else if (sel_id) begin
        nxt_rise.id_sh = ID_CODE;
      end else begin
        nxt_rise.byp = 1'b0;
      end
    end else if (rise_ff.st == bst_pkg::ST_SH_DR) begin
      if (sel_bs) begin
        nxt_rise.bs_sh = {tdi_eff, rise_ff.bs_sh[BSR_LEN-1:1]};
      end else if (sel_id) begin
        nxt_rise.id_sh = {tdi_eff, rise_ff.id_sh[ID_W-1:1]};
      end else begin
        nxt_rise.byp = tdi_eff;
      end
    end else if (rise_ff.st == bst_pkg::ST_UPD_DR) begin
      // Preload also happens under sample-float and sample/preload
      if (sel_bs) begin
        nxt_rise.bs_upd = rise_ff.bs_sh;
      end
    end

    // Any change the memory side must see flips the toggle
    if ((nxt_rise.ir != rise_ff.ir) || (nxt_rise.bs_upd != rise_ff.bs_upd)) begin
      nxt_rise.upd_tgl = ~rise_ff.upd_tgl;
    end
  end

  // Power-up reset puts the controller in reset with the identification instruction
  always_ff @(posedge I_TCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rise_ff.st      <= bst_pkg::ST_TLR;
      rise_ff.ir      <= OP_IDCODE;
      rise_ff.ir_sh   <= '0;
      rise_ff.byp     <= 1'b0;
      rise_ff.id_sh   <= '0;
      rise_ff.bs_sh   <= '0;
      rise_ff.bs_upd  <= UPD_RST;
      rise_ff.ring_s1 <= '0;
      rise_ff.ring_s2 <= '0;
      rise_ff.upd_tgl <= 1'b0;
    end else begin
      rise_ff <= nxt_rise;
    end
  end

  always_comb begin
    nxt_fall.tdo_oe = in_shift;
    if (rise_ff.st == bst_pkg::ST_SH_IR) begin
      nxt_fall.tdo = rise_ff.ir_sh[0];
    end else if (rise_ff.st != bst_pkg::ST_SH_DR) begin
      nxt_fall.tdo = 1'b0;
    end else if (sel_bs) begin
      nxt_fall.tdo = rise_ff.bs_sh[0];
    end else if (sel_id) begin
      nxt_fall.tdo = rise_ff.id_sh[0];
    end else begin
      nxt_fall.tdo = rise_ff.byp;
    end
  end

  // Output stage runs half a test clock behind the shift registers
  always_ff @(negedge I_TCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fall_ff <= '0;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

  assign O_TDO    = fall_ff.tdo;
  assign O_TDO_OE = fall_ff.tdo_oe;

  // Instruction and preload words are held for many test clocks after the
  // toggle flips, so the memory side may copy them once the toggle is seen
  always_comb begin
    nxt_sys        = sys_ff;
    nxt_sys.tgl_s1 = rise_ff.upd_tgl;
    nxt_sys.tgl_s2 = sys_ff.tgl_s1;
    nxt_sys.tgl_s3 = sys_ff.tgl_s2;
    if (sys_ff.tgl_s2 != sys_ff.tgl_s3) begin
      nxt_sys.mode.ovr = (rise_ff.ir == OP_EXTEST);
      nxt_sys.mode.flt = (rise_ff.ir == OP_SAMPZ) ||
                         ((rise_ff.ir == OP_EXTEST) && !rise_ff.bs_upd[OE_CELL]);
      nxt_sys.val      = rise_ff.bs_upd;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_ff.tgl_s1 <= 1'b0;
      sys_ff.tgl_s2 <= 1'b0;
      sys_ff.tgl_s3 <= 1'b0;
      sys_ff.mode   <= '0;
      sys_ff.val    <= UPD_RST;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign O_RING_OVR   = sys_ff.mode.ovr;
  assign O_RING_VAL   = sys_ff.val;
  assign O_QBUS_FLOAT = sys_ff.mode.flt;

  // Run of consecutive high mode-select edges, saturating
  logic [2:0] tms_run_ff;

  always_ff @(posedge I_TCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tms_run_ff <= 3'h0;
    end else if (!tms_eff) begin
      tms_run_ff <= 3'h0;
    end else if (tms_run_ff != `BST_RST_TMS_CNT) begin
      tms_run_ff <= tms_run_ff + 3'h1;
    end
  end

  AST_TMS_FIVE_RESET: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (tms_run_ff == `BST_RST_TMS_CNT) |-> (rise_ff.st == bst_pkg::ST_TLR))
    else $error("five high mode-select edges did not reach reset");

  AST_RESET_HOLDS_ID: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_TLR) |=> (rise_ff.ir == OP_IDCODE))
    else $error("instruction is not identification after reset state");

  AST_CAPIR_PATTERN: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_CAP_IR) |=> (rise_ff.ir_sh[1:0] == `BST_IR_CAPT))
    else $error("capture-IR pattern wrong");

  AST_BYPASS_CLEAR: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_CAP_DR) && sel_byp |=> !rise_ff.byp)
    else $error("bypass bit not cleared at capture");

  AST_BYPASS_SHIFT: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_SH_DR) && sel_byp |=> (rise_ff.byp == $past(tdi_eff)))
    else $error("bypass bit did not take serial input");

  AST_TLR_OE_PRESET: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_TLR) |=> rise_ff.bs_upd[OE_CELL])
    else $error("enable cell not preset in reset state");

  AST_ID_CAPTURE: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_CAP_DR) && sel_id |=> (rise_ff.id_sh == ID_CODE))
    else $error("identification code not captured");

  AST_BS_CAPTURE: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_CAP_DR) && sel_bs |=> (rise_ff.bs_sh == $past(rise_ff.ring_s2)))
    else $error("boundary register did not capture the ring");

  AST_IR_ONLY_AT_UPDATE: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    $changed(rise_ff.ir) |-> ($past(rise_ff.st) == bst_pkg::ST_UPD_IR) ||
                             ($past(rise_ff.st) == bst_pkg::ST_TLR))
    else $error("instruction changed outside update-IR");

  AST_TDO_ONLY_SHIFT: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    O_TDO_OE == in_shift)
    else $error("serial out enable outside shift states");

  AST_TDO_LSB_IR: assert property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_SH_IR) && $stable(rise_ff.st) |-> (O_TDO == rise_ff.ir_sh[0]))
    else $error("serial out not from instruction LSB");

  AST_EXTEST_OE_FLOAT: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_RING_OVR && !O_RING_VAL[OE_CELL] |-> O_QBUS_FLOAT)
    else $error("read bus not floated with enable cell low");

  COV_ID_SHIFT: cover property (
    @(posedge I_TCK) disable iff (!I_RST_N)
    (rise_ff.st == bst_pkg::ST_SH_DR) && sel_id);

  COV_EXTEST_ON: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    $rose(O_RING_OVR));

  COV_FLOAT_ON: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    $rose(O_QBUS_FLOAT));

endmodule

/* testbench/bst_ctl_model.sv */
// Board-level test controller model driving the serial test port
module bst_ctl_model (
  output logic      o_tck,     // Test clock, low between frames
  output logic      o_tms,     // Mode select level
  output logic      o_tms_drv, // Mode select driven
  output logic      o_tdi,     // Data in level
  output logic      o_tdi_drv, // Data in driven
  input  wire logic i_tdo,     // Serial data out
  input  wire logic i_tdo_oe   // Serial data out enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tdo_last;
  logic oe_bad;
  initial begin
    o_tck     = 1'b0;
    o_tms     = 1'b1;
    o_tms_drv = 1'b1;
    o_tdi     = 1'b1;
    o_tdi_drv = 1'b1;
    tdo_last  = 1'b0;
    oe_bad    = 1'b0;
  end
  // One test clock period; levels move only while the clock is low
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
    // An undriven line wanders, so only the pull-up reading can make it look high
    o_tms = o_tms_drv ? tms : ~o_tms;
    o_tdi = o_tdi_drv ? tdi : ~o_tdi;
    #6 o_tck = 1'b1;
    tdo = i_tdo_oe ? i_tdo : ~tdo_last;
    oe = i_tdo_oe;
    tdo_last = tdo;
    #6 o_tck = 1'b0;
  endtask
  task automatic seq(input logic [7:0] tms, input int n);
    logic t;
    logic e;
    for (int i = 0; i < n; i++) tick(tms[i], 1'b1, t, e);
  endtask
  // Scan from idle back to idle, passing through the update state
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic e;
    dout   = '0;
    oe_bad = 1'b0;
    seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i], e);
      oe_bad = oe_bad | ~e;
    end
    seq(8'h01, 2);
  endtask
  // Lets data in float so only the pull-up reading can make it high
  task automatic float_tdi(input logic f);
    o_tdi_drv = ~f;
  endtask
  task automatic treset(input logic drv);
    o_tms_drv = drv;
    seq(8'h1f, 5);
    o_tms_drv = 1'b1;
    seq(8'h00, 1);
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the boundary-scan test access port
`include "bst_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          BL   = `BST_BSR_LEN;
  localparam logic [127:0] PAT  = 128'h9e3c_a5f1_0c7d_4b62_e815_37a9_d04f_6b2c;
  localparam logic [127:0] B47  = 128'h1 << `BST_OE_CELL;
  localparam logic [127:0] MSK  = (128'h1 << BL) - 128'h1;
  localparam logic [8:0]   BOPS = {`BST_OP_EXTEST, `BST_OP_SAMPLE, `BST_OP_SAMPZ};
  logic          sys_clk;
  logic          rst_n;
  logic          tck;
  logic          tms;
  logic          tms_drv;
  logic          tdi;
  logic          tdi_drv;
  logic          tdo;
  logic          tdo_oe;
  logic          ovr;
  logic          flt;
  logic [BL-1:0] ring;
  logic [BL-1:0] rv;
  logic [127:0]  d;
  int            errors      = 0;
  int            comparisons = 0;
  int            cycles      = 0;

  always #12.5 sys_clk = ~sys_clk;

  bst_top #(.BSR_LEN(BL)) i_dut (
    .I_SYS_CLK    (sys_clk),
    .I_RST_N      (rst_n),
    .I_TCK        (tck),
    .I_TMS        (tms),
    .I_TMS_DRV    (tms_drv),
    .I_TDI        (tdi),
    .I_TDI_DRV    (tdi_drv),
    .I_RING       (ring),
    .O_TDO        (tdo),
    .O_TDO_OE     (tdo_oe),
    .O_RING_OVR   (ovr),
    .O_RING_VAL   (rv),
    .O_QBUS_FLOAT (flt)
  );

  bst_ctl_model i_ctl (
    .o_tck     (tck),
    .o_tms     (tms),
    .o_tms_drv (tms_drv),
    .o_tdi     (tdi),
    .o_tdi_drv (tdi_drv),
    .i_tdo     (tdo),
    .i_tdo_oe  (tdo_oe)
  );

  task automatic conclude();
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ir(input logic [2:0] op);
    i_ctl.scan(1'b1, 3, {125'h0, op}, d);
  endtask

  // Memory-side copies trail the test clock by up to three system clocks
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_power_id();
    check(tdo_oe, 1'b0);
    check(128'(rv), B47);
    i_ctl.seq(8'h00, 1);
    i_ctl.scan(1'b0, 32, '0, d);
    check(d, 128'(`BST_IDCODE));
    check(i_ctl.oe_bad, 1'b0);
    check(tdo_oe, 1'b0);
  endtask

  task automatic t_bypass(input logic [2:0] op);
    ir(op);
    check(d, 128'h1);
    i_ctl.scan(1'b0, 8, 128'hb5, d);
    check(d, 128'h6a);
    i_ctl.float_tdi(1'b1);
    i_ctl.scan(1'b0, 8, 128'h0, d);
    i_ctl.float_tdi(1'b0);
    check(d, 128'hfe);
  endtask

  task automatic t_boundary();
    @(posedge sys_clk);
    ring <= PAT[BL-1:0];
    for (int k = 0; k < 3; k++) begin
      ir(BOPS[3*k +: 3]);
      i_ctl.scan(1'b0, BL, ~PAT & ~B47, d);
      check(d & MSK, PAT & MSK);
      settle();
      check({ovr, flt}, k == 0 ? 2'b01 : k == 1 ? 2'b00 : 2'b11);
    end
    check(128'(rv), ~PAT & ~B47 & MSK);
    i_ctl.scan(1'b0, BL, ~PAT | B47, d);
    settle();
    check({ovr, flt}, 2'b10);
  endtask

  task automatic t_tms_reset();
    // Enable cell low first so the preset is visible; reset from Shift-IR avoids Update-DR
    i_ctl.scan(1'b0, BL, ~PAT & ~B47, d);
    i_ctl.seq(8'h03, 4);
    i_ctl.treset(1'b0);
    check(tdo_oe, 1'b0);
    settle();
    check({ovr, flt}, 2'b00);
    check(128'(rv), (~PAT | B47) & MSK);
    i_ctl.scan(1'b0, 32, '0, d);
    check(d, 128'(`BST_IDCODE));
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      conclude();
    end
  end

  initial begin
    sys_clk = 1'b0;
    rst_n   = 1'b0;
    ring    = '0;
    // Test clock pulses during reset so both domains see it
    i_ctl.seq(8'h1f, 5);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    #3;
    t_power_id();
    t_bypass(`BST_OP_BYPASS);
    t_bypass(3'h3);
    t_bypass(3'h5);
    t_bypass(3'h6);
    t_boundary();
    t_tms_reset();
    conclude();
  end
endmodule
